/* hw/pmsc_defs.vh */
// Purpose: Offsets, field positions, reset values and timing for the power status block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Included by its bare name.
`ifndef PMSC_DEFS_VH
`define PMSC_DEFS_VH
`define PMSC_OFF_CTRL_ONE   8'h00
`define PMSC_OFF_CTRL_TWO   8'h04
`define PMSC_OFF_OPTS_TWO   8'h08
`define PMSC_DETECT_FLAG    7
`define PMSC_DETECT_ACK     6
`define PMSC_IRQ_EN         5
`define PMSC_RESET_EN       4
`define PMSC_STOP_EN        3
`define PMSC_LOGIC_EN       2
`define PMSC_RSVD_ONE       1
`define PMSC_REF_BUF_EN     0
`define PMSC_WARN_FLAG      7
`define PMSC_WARN_ACK       6
`define PMSC_DETECT_TRIP    5
`define PMSC_WARN_TRIP      4
`define PMSC_RECOV_FLAG     3
`define PMSC_RECOV_ACK      2
`define PMSC_DEEP_SEL       0
`define PMSC_WDOG_CLK_SEL   7
`define PMSC_TIMER_CLK_CFG  6
`define PMSC_RST_STOP_EN    1'h0
`define PMSC_RST_RESET_EN   1'h0
`define PMSC_RST_LOGIC_EN   1'h0
`define PMSC_RST_WDOG_SEL   1'h0
`define PMSC_RST_TIMER_CFG  1'h0
`define PMSC_SYNC_STAGES    2
`endif

/* hw/pmsc_top.v */
// Purpose: Low-voltage supervision status/control and stop flavour selection behind APB.
// Assumes: Comparator outputs and timer clock pins are asynchronous to pclk.
// Notes:   One wait state on every APB access; por_n only clears power-on-only state.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "pmsc_defs.vh"
module pmsc_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        por_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        undervolt_cmp,
    input  wire        warning_cmp,
    input  wire        in_stop,
    input  wire        deep_stop_wake,
    input  wire        shared_timer_ext_clock,
    input  wire        first_timer_ext_clock,
    input  wire        second_timer_ext_clock,
    output reg         undervolt_irq,
    output reg         undervolt_reset_req,
    output reg         undervolt_detector_on,
    output reg         reference_buffer_enable,
    output reg         undervolt_trip_select,
    output reg         warning_trip_select,
    output reg         deep_stop_select,
    output reg         watchdog_clk_select,
    output reg         timer1_clk,
    output reg         timer2_clk,
    output reg         timer3_clk
);
    reg  [1:0]  uv_sync_q;
    reg  [1:0]  warn_sync_q;
    reg  [2:0]  tclk_meta_q;
    reg  [2:0]  tclk_sync_q;
    reg         detect_flag_q;
    reg         irq_en_q;
    reg         reset_en_q;
    reg         stop_en_q;
    reg         logic_en_q;
    reg         ref_buf_q;
    reg         warn_flag_q;
    reg         detect_trip_q;
    reg         warn_trip_q;
    reg         recov_flag_q;
    reg         deep_sel_q;
    reg         wdog_sel_q;
    reg         timer_cfg_q;
    reg         once_one_q;
    reg         once_two_q;
    reg         once_opts_q;
    reg         once_por_q;
    reg  [31:0] rdata_d;
    reg         hit_d;
    wire        access;
    wire        wr_commit;
    wire        wr_one;
    wire        wr_two;
    wire        wr_opts;
    wire        uv_level;
    wire        warn_level;
    wire        detect_active;

    // Only the low byte lane carries register bits.
    assign access    = psel & penable;
    assign wr_commit = access & pready & pwrite & pstrb[0] & ~pslverr;
    assign wr_one    = wr_commit & (paddr == `PMSC_OFF_CTRL_ONE);
    assign wr_two    = wr_commit & (paddr == `PMSC_OFF_CTRL_TWO);
    assign wr_opts   = wr_commit & (paddr == `PMSC_OFF_OPTS_TWO);
    assign uv_level   = uv_sync_q[1];
    assign warn_level = warn_sync_q[1];
    // Detection is off in stop unless the stop enable keeps it on.
    assign detect_active = logic_en_q & (~in_stop | stop_en_q);

    // The first stage is read only by the second stage.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_sync_q   <= 2'h0;
            warn_sync_q <= 2'h0;
            tclk_meta_q <= 3'h0;
            tclk_sync_q <= 3'h0;
        end else begin
            uv_sync_q   <= {uv_sync_q[0], undervolt_cmp};
            warn_sync_q <= {warn_sync_q[0], warning_cmp};
            tclk_meta_q <= {second_timer_ext_clock, first_timer_ext_clock,
                            shared_timer_ext_clock};
            tclk_sync_q <= tclk_meta_q;
        end
    end

    always @* begin
        rdata_d = 32'h0000_0000;
        hit_d   = 1'b1;
        case (paddr)
            `PMSC_OFF_CTRL_ONE: begin
                rdata_d[`PMSC_DETECT_FLAG] = detect_flag_q & logic_en_q;
                rdata_d[`PMSC_IRQ_EN]      = irq_en_q;
                rdata_d[`PMSC_RESET_EN]    = reset_en_q;
                rdata_d[`PMSC_STOP_EN]     = stop_en_q;
                rdata_d[`PMSC_LOGIC_EN]    = logic_en_q;
                rdata_d[`PMSC_REF_BUF_EN]  = ref_buf_q;
            end
            `PMSC_OFF_CTRL_TWO: begin
                rdata_d[`PMSC_WARN_FLAG]   = warn_flag_q;
                rdata_d[`PMSC_DETECT_TRIP] = detect_trip_q;
                rdata_d[`PMSC_WARN_TRIP]   = warn_trip_q;
                rdata_d[`PMSC_RECOV_FLAG]  = recov_flag_q;
                rdata_d[`PMSC_DEEP_SEL]    = deep_sel_q;
            end
            `PMSC_OFF_OPTS_TWO: begin
                rdata_d[`PMSC_WDOG_CLK_SEL]  = wdog_sel_q;
                rdata_d[`PMSC_TIMER_CLK_CFG] = timer_cfg_q;
            end
            default: begin
                hit_d = 1'b0;
            end
        endcase
    end

    // One wait state keeps read data and the answer both straight from flops.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            if (access & ~pready) begin
                pready  <= 1'b1;
                pslverr <= ~hit_d;
                prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // Reserved bit 1 is not stored, so a stray one written there has no effect.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detect_flag_q <= 1'b0;
            irq_en_q      <= 1'b0;
            reset_en_q    <= `PMSC_RST_RESET_EN;
            stop_en_q     <= `PMSC_RST_STOP_EN;
            logic_en_q    <= `PMSC_RST_LOGIC_EN;
            ref_buf_q     <= 1'b0;
            once_one_q    <= 1'b0;
        end else begin
            if (detect_active & uv_level) begin
                detect_flag_q <= 1'b1;
            end else if (wr_one & pwdata[`PMSC_DETECT_ACK]) begin
                detect_flag_q <= 1'b0;
            end
            if (wr_one) begin
                irq_en_q   <= pwdata[`PMSC_IRQ_EN];
                stop_en_q  <= pwdata[`PMSC_STOP_EN];
                logic_en_q <= pwdata[`PMSC_LOGIC_EN];
                ref_buf_q  <= pwdata[`PMSC_REF_BUF_EN];
                once_one_q <= 1'b1;
            end
            if (wr_one & ~once_one_q) begin
                reset_en_q <= pwdata[`PMSC_RESET_EN];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_flag_q  <= 1'b0;
            recov_flag_q <= 1'b0;
            deep_sel_q   <= 1'b0;
            once_two_q   <= 1'b0;
            wdog_sel_q   <= `PMSC_RST_WDOG_SEL;
            timer_cfg_q  <= `PMSC_RST_TIMER_CFG;
            once_opts_q  <= 1'b0;
        end else begin
            // A present warning holds the flag, so the acknowledge loses to it.
            if (warn_level) begin
                warn_flag_q <= 1'b1;
            end else if (wr_two & pwdata[`PMSC_WARN_ACK]) begin
                warn_flag_q <= 1'b0;
            end
            if (deep_stop_wake) begin
                recov_flag_q <= 1'b1;
            end else if (wr_two & pwdata[`PMSC_RECOV_ACK]) begin
                recov_flag_q <= 1'b0;
            end
            if (wr_two & ~once_two_q) begin
                deep_sel_q <= pwdata[`PMSC_DEEP_SEL];
                once_two_q <= 1'b1;
            end
            if (wr_opts) begin
                timer_cfg_q <= pwdata[`PMSC_TIMER_CLK_CFG];
                once_opts_q <= 1'b1;
            end
            if (wr_opts & ~once_opts_q) begin
                wdog_sel_q <= pwdata[`PMSC_WDOG_CLK_SEL];
            end
        end
    end

    // Trip selects survive every reset except power-on.
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            detect_trip_q <= 1'b0;
            warn_trip_q   <= 1'b0;
            once_por_q    <= 1'b0;
        end else begin
            if (wr_two) begin
                warn_trip_q <= pwdata[`PMSC_WARN_TRIP];
            end
            if (wr_two & ~once_por_q) begin
                detect_trip_q <= pwdata[`PMSC_DETECT_TRIP];
                once_por_q    <= 1'b1;
            end
        end
    end

    // Routed timer clocks are resampled, so they must stay well below pclk/2.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            undervolt_irq           <= 1'b0;
            undervolt_reset_req     <= 1'b0;
            undervolt_detector_on   <= 1'b0;
            reference_buffer_enable <= 1'b0;
            undervolt_trip_select   <= 1'b0;
            warning_trip_select     <= 1'b0;
            deep_stop_select        <= 1'b0;
            watchdog_clk_select     <= 1'b0;
            timer1_clk              <= 1'b0;
            timer2_clk              <= 1'b0;
            timer3_clk              <= 1'b0;
        end else begin
            undervolt_irq           <= irq_en_q & logic_en_q & detect_flag_q;
            undervolt_reset_req     <= reset_en_q & logic_en_q & detect_flag_q;
            undervolt_detector_on   <= detect_active;
            reference_buffer_enable <= ref_buf_q;
            undervolt_trip_select   <= detect_trip_q;
            warning_trip_select     <= warn_trip_q;
            deep_stop_select        <= deep_sel_q;
            watchdog_clk_select     <= wdog_sel_q;
            if (timer_cfg_q) begin
                timer1_clk <= tclk_sync_q[1];
                timer2_clk <= tclk_sync_q[2];
                timer3_clk <= tclk_sync_q[0];
            end else begin
                timer1_clk <= tclk_sync_q[0];
                timer2_clk <= tclk_sync_q[0];
                timer3_clk <= tclk_sync_q[0];
            end
        end
    end
endmodule // pmsc_top

/* testbench/pmsc_monitor.sv */
// Purpose: Port checks for the power status block.
// Assumes: One wait state per APB access.
// Notes:   Bound to pmsc_top below.
`timescale 1ns/1ps
module pmsc_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        in_stop,
    input wire logic        shared_timer_ext_clock,
    input wire logic        undervolt_irq,
    input wire logic        undervolt_reset_req,
    input wire logic        undervolt_detector_on,
    input wire logic        reference_buffer_enable,
    input wire logic        timer3_clk
);
    // Counts edges since reset so the pin pipeline is full before it is judged.
    logic [2:0] up_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd1;
        pready && !pwrite && !pslverr && paddr == 8'h00;
    endsequence
    property p_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
    property p_err;
        pready && !(paddr inside {8'h00, 8'h04, 8'h08}) |-> pslverr && prdata == 32'h0;
    endproperty
    property p_zero;
        s_rd1 |-> prdata[6] == 1'h0 && prdata[1] == 1'h0 && prdata[31:8] == 24'h0;
    endproperty
    property p_off; s_rd1 ##0 !prdata[2] |-> !prdata[7] ##1 !undervolt_detector_on[*2]; endproperty
    property p_irq; s_rd1 ##0 (prdata[7] && prdata[5] && prdata[2]) |-> ##[0:2] undervolt_irq;
    endproperty
    property p_rst;
        s_rd1 ##0 (prdata[7] && prdata[4] && prdata[2]) |-> ##[0:2] undervolt_reset_req;
    endproperty
    property p_stop; s_rd1 ##0 prdata[3:2] == 2'h1 ##1 in_stop[*2] |-> !undervolt_detector_on;
    endproperty
    property p_buf;
        pready && pwrite && paddr == 8'h00 && pstrb[0] |=> ##1
            reference_buffer_enable == $past(pwdata[0], 2);
    endproperty
    property p_tmr; up_q == 3'h7 |-> timer3_clk == $past(shared_timer_ext_clock, 3); endproperty
    a_wait: assert property (p_wait) else $error("access did not end after one wait state");
    a_err: assert property (p_err) else $error("unmapped access not refused");
    a_zero: assert property (p_zero) else $error("write-only or reserved bit reads one");
    a_off: assert property (p_off) else $error("disabled detection still active");
    a_irq: assert property (p_irq) else $error("interrupt request missing");
    a_rst: assert property (p_rst) else $error("reset request missing");
    a_stop: assert property (p_stop) else $error("detection runs in stop");
    a_buf: assert property (p_buf) else $error("buffer enable wrong");
    a_tmr: assert property (p_tmr) else $error("third timer clock wrong");
endmodule // pmsc_monitor
bind pmsc_top pmsc_monitor u_pmsc_monitor (.*);

/* testbench/testbench.sv */
// Purpose: APB register tests of the power status block.
// Assumes: 20 MHz pclk, one wait state per access.
// Notes:   Comparators are driven as clean levels.
`timescale 1ns/1ps
module testbench;
    logic        pclk = 1'h0, presetn = 1'h0, por_n = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, got_data;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, got_err;
    logic        undervolt_cmp = 1'h0, warning_cmp = 1'h0, in_stop = 1'h0;
    logic        deep_stop_wake = 1'h0, shared_timer_ext_clock = 1'h0;
    logic        first_timer_ext_clock = 1'h0, second_timer_ext_clock = 1'h0;
    logic        undervolt_irq, undervolt_reset_req, undervolt_detector_on;
    logic        reference_buffer_enable, undervolt_trip_select, warning_trip_select;
    logic        deep_stop_select, watchdog_clk_select, timer1_clk, timer2_clk, timer3_clk;
    int          miscompares = 0, cmp_count = 0;
    pmsc_top u_pmsc_top (.*);
    always #25 pclk = ~pclk;
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Entered right after an edge; the idle cycle at the end keeps psel from two drives.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
        if (n >= 20) miscompares++;
        got_data = prdata;
        got_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'h0, a, 32'h0);
        chk(got_data, exp);
    endtask
    initial begin
        #100000;
        miscompares++;
        conclude();
    end
    initial begin
        cyc(6);
        presetn <= 1'h1;
        por_n <= 1'h1;
        @(posedge pclk);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        xfer(1'h0, 8'h0C, 32'h0);
        chkb(got_err, 1'h1);
        wr(8'h00, 32'h3D);
        rd(8'h00, 32'h3D);
        chkb(reference_buffer_enable, 1'h1);
        undervolt_cmp <= 1'h1;
        cyc(5);
        rd(8'h00, 32'hBD);
        chkb(undervolt_irq, 1'h1);
        chkb(undervolt_reset_req, 1'h1);
        undervolt_cmp <= 1'h0;
        cyc(4);
        wr(8'h00, 32'h6C);
        rd(8'h00, 32'h3C);
        wr(8'h00, 32'h28);
        undervolt_cmp <= 1'h1;
        cyc(5);
        rd(8'h00, 32'h38);
        chkb(undervolt_detector_on, 1'h0);
        undervolt_cmp <= 1'h0;
        wr(8'h00, 32'h04);
        in_stop <= 1'h1;
        rd(8'h00, 32'h14);
        chkb(undervolt_detector_on, 1'h0);
        wr(8'h00, 32'h0C);
        cyc(1);
        chkb(undervolt_detector_on, 1'h1);
        in_stop <= 1'h0;
        wr(8'h04, 32'h31);
        rd(8'h04, 32'h31);
        chk({29'h0, undervolt_trip_select, warning_trip_select, deep_stop_select}, 32'h7);
        wr(8'h04, 32'h00);
        rd(8'h04, 32'h21);
        chkb(warning_trip_select, 1'h0);
        warning_cmp <= 1'h1;
        cyc(5);
        rd(8'h04, 32'hA1);
        wr(8'h04, 32'h40);
        rd(8'h04, 32'hA1);
        warning_cmp <= 1'h0;
        cyc(5);
        rd(8'h04, 32'hA1);
        wr(8'h04, 32'h40);
        rd(8'h04, 32'h21);
        deep_stop_wake <= 1'h1;
        @(posedge pclk);
        deep_stop_wake <= 1'h0;
        cyc(2);
        rd(8'h04, 32'h29);
        wr(8'h04, 32'h04);
        rd(8'h04, 32'h21);
        wr(8'h08, 32'hC0);
        @(posedge pclk);
        chkb(watchdog_clk_select, 1'h1);
        wr(8'h08, 32'h00);
        rd(8'h08, 32'h80);
        shared_timer_ext_clock <= 1'h1;
        cyc(4);
        chk({29'h0, timer1_clk, timer2_clk, timer3_clk}, 32'h7);
        wr(8'h08, 32'h40);
        first_timer_ext_clock <= 1'h1;
        cyc(4);
        chk({29'h0, timer1_clk, timer2_clk, timer3_clk}, 32'h5);
        presetn <= 1'h0;
        cyc(2);
        presetn <= 1'h1;
        @(posedge pclk);
        rd(8'h04, 32'h20);
        rd(8'h08, 32'h0);
        wr(8'h04, 32'h01);
        rd(8'h04, 32'h21);
        conclude();
    end
endmodule // testbench
